// >>> core/flash_ctl.sv
// flash self-access controller: indirect registers, read, buffered four-word write
// assumes a single-cycle register port from the core and straps for protection
//
// How it works
// - flash read and written in normal operation, no special mode
// - flash reached only through six indirect registers
// - data registers form 14-bit word, address registers 12-bit address, zero-extended to 13
// - array holds 4K words, 0000h to 0FFFh
// - reads return one word, writes commit four words
// - committing write erases the row first, automatically
// - internal timer times write; write trigger clears at end
// - self access still works under code protection
// - protect field blocks writes to chosen blocks; reads stay allowed
// - code protect denies serial programming port access
// - triggers start read or write; software can only set them
// - hardware clears triggers when the operation ends
// - writes only with write enable set; cleared at reset
// - calibration select makes reads target the test area
// - write started with calibration select set does nothing
// - unlock register has no storage and reads zero
// - unlock register only gates the write sequence
// - 55h then AAh to unlock must precede the write trigger
// - read happens second cycle after trigger, data next cycle
// - write at low bits 11 erases sixteen and programs four
// - control bits 0 read, 1 write, 2 enable, 6 calibration, 7 one
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_map.svh"

module flash_ctl (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [1:0]  self_write_protect_field_i,
  input  wire logic        code_protect_bit_n_i,
  input  wire logic        serial_port_req_i,
  output logic             serial_port_grant_o,
  output logic             busy_o
);

  // ***********************************************************
  // storage
  // ***********************************************************
  // 4K user words
  logic [`WORD_W-1:0] user_mem [0:4095];
  logic [`WORD_W-1:0] buf_q    [0:3];

  flash_ctl_pkg::ptr_type    ptr_q;
  flash_ctl_pkg::state_type  state_q;
  flash_ctl_pkg::unlock_type unlock_q;
  logic                      rd_q;
  logic                      wr_q;
  logic                      write_enable_bit_q;
  logic                      calibration_space_select_q;
  logic [15:0]               timer_q;
  logic [1:0]                prot_s1_q;
  logic [1:0]                prot_q;
  logic                      cp_s1_q;
  logic                      cp_n_q;
  logic                      req_s1_q;
  logic                      req_q;
  logic [3:0]                cnt_q;
  logic                      prog_q;
  logic [9:0]                row_q;

  wire logic [`ADDR_W-1:0] addr = {1'b0, ptr_q.addr_high, ptr_q.addr_low};
  wire logic [1:0]         lo2  = ptr_q.addr_low[1:0];
  wire logic wr_cmd  = reg_write_i && reg_addr_i == `FLASH_CONTROL_OFS;
  wire logic ul_cmd  = reg_write_i && reg_addr_i == `FLASH_UNLOCK_OFS;
  // enable and calibration select as written by the same control write
  wire logic new_write_enable_bit = reg_wdata_i[`CTL_WRITE_ENABLE_BIT_BIT];
  wire logic new_cal  = reg_wdata_i[`CTL_CALIBRATION_SPACE_SELECT_BIT];
  wire logic set_rd  = wr_cmd && reg_wdata_i[`CTL_READ_BIT] && !rd_q && !wr_q;
  // write start only when unlocked and enabled
  wire logic set_wr  = wr_cmd && reg_wdata_i[`CTL_WRITE_BIT] && !wr_q && !rd_q
                       && new_write_enable_bit && unlock_q == flash_ctl_pkg::UL_OPEN;

  function automatic logic blocked(input logic [1:0] f, input logic [11:0] a);
    case (f)
      2'b11:   blocked = 1'b0;
      2'b10:   blocked = a < 12'h400;
      2'b01:   blocked = a < 12'h800;
      default: blocked = 1'b1;
    endcase
  endfunction : blocked

  // ***********************************************************
  // strap synchronisers
  // ***********************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prot_s1_q <= 2'b11;
      prot_q    <= 2'b11;
      cp_s1_q   <= 1'b1;
      cp_n_q    <= 1'b1;
      req_s1_q  <= 1'b0;
      req_q     <= 1'b0;
    end else begin
      prot_s1_q <= self_write_protect_field_i;
      prot_q    <= prot_s1_q;
      cp_s1_q   <= code_protect_bit_n_i;
      cp_n_q    <= cp_s1_q;
      req_s1_q  <= serial_port_req_i;
      req_q     <= req_s1_q;
    end
  end

  // serial port denied under code protect
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) serial_port_grant_o <= 1'b0;
    else          serial_port_grant_o <= req_q && cp_n_q;
  end

  // ***********************************************************
  // unlock sequence
  // ***********************************************************
  // unlock sequence tracking
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      unlock_q <= flash_ctl_pkg::UL_NONE;
    end else if (ul_cmd) begin
      if (reg_wdata_i == `UNLOCK_FIRST)
        unlock_q <= flash_ctl_pkg::UL_FIRST;
      else if (reg_wdata_i == `UNLOCK_SECOND && unlock_q == flash_ctl_pkg::UL_FIRST)
        unlock_q <= flash_ctl_pkg::UL_OPEN;
      else
        unlock_q <= flash_ctl_pkg::UL_NONE;
    end else if (reg_write_i) begin
      unlock_q <= (unlock_q == flash_ctl_pkg::UL_OPEN && !wr_cmd)
                  ? flash_ctl_pkg::UL_OPEN : flash_ctl_pkg::UL_NONE;
    end
  end

  // ***********************************************************
  // control register
  // ***********************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      write_enable_bit_q   <= 1'b0;
      calibration_space_select_q <= 1'b0;
    end else if (wr_cmd) begin
      // enable cleared at reset, set by software
      write_enable_bit_q   <= reg_wdata_i[`CTL_WRITE_ENABLE_BIT_BIT];
      calibration_space_select_q <= reg_wdata_i[`CTL_CALIBRATION_SPACE_SELECT_BIT];
    end
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q <= flash_ctl_pkg::ST_IDLE;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      timer_q <= 16'h0000;
      cnt_q   <= 4'h0;
      prog_q  <= 1'b0;
      row_q   <= 10'h000;
    end else begin
      case (state_q)
        flash_ctl_pkg::ST_IDLE: begin
          if (set_rd) begin
            rd_q    <= 1'b1;
            state_q <= flash_ctl_pkg::ST_RWAIT;
          end else if (set_wr) begin
            wr_q  <= 1'b1;
            // row held so later address writes cannot move the erase
            row_q <= addr[11:2];
            if (!new_cal && lo2 == 2'b11 && !blocked(prot_q, addr[11:0])) begin
              cnt_q   <= 4'h0;
              prog_q  <= 1'b1;
              timer_q <= 16'(`WRITE_CYCLES);
              state_q <= flash_ctl_pkg::ST_ERASE;
            end else begin
              prog_q  <= 1'b0;
              timer_q <= 16'h0001;
              state_q <= flash_ctl_pkg::ST_PROG;
            end
          end
        end
        // one cycle wait, read in second cycle
        flash_ctl_pkg::ST_RWAIT: state_q <= flash_ctl_pkg::ST_READ;
        flash_ctl_pkg::ST_READ: begin
          rd_q    <= 1'b0;
          state_q <= flash_ctl_pkg::ST_IDLE;
        end
        flash_ctl_pkg::ST_ERASE: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'hf) begin
            timer_q <= 16'(`WRITE_CYCLES);
            state_q <= flash_ctl_pkg::ST_PROG;
          end
        end
        flash_ctl_pkg::ST_PROG: begin
          if (timer_q <= 16'h0001) begin
            wr_q    <= 1'b0;
            prog_q  <= 1'b0;
            state_q <= flash_ctl_pkg::ST_IDLE;
          end else begin
            timer_q <= timer_q - 16'h0001;
          end
        end
        default: state_q <= flash_ctl_pkg::ST_IDLE;
      endcase
    end
  end

  // ***********************************************************
  // array and buffer
  // ***********************************************************
  wire logic commit = state_q == flash_ctl_pkg::ST_PROG && timer_q <= 16'h0001 && prog_q;

  always_ff @(posedge clk_sys_i) begin
    // every write without calibration select loads the buffer slot
    if (set_wr && !new_cal)
      buf_q[lo2] <= {ptr_q.data_high, ptr_q.data_low};
    if (state_q == flash_ctl_pkg::ST_ERASE)
      user_mem[{row_q[9:2], cnt_q}] <= {`WORD_W{1'b1}};
    if (commit) begin
      for (int i = 0; i < 4; i++)
        user_mem[{row_q, 2'(i)}] <= buf_q[i];
    end
  end

  // ***********************************************************
  // indirect registers
  // ***********************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ptr_q <= '0;
    end else if (state_q == flash_ctl_pkg::ST_READ) begin
      // read word into data registers
      // calibration words fixed in the test area
      {ptr_q.data_high, ptr_q.data_low} <= calibration_space_select_q ? {`CAL_FILL, addr[3:0]}
                                                    : user_mem[addr[11:0]];
    end else if (reg_write_i) begin
      case (reg_addr_i)
        `FLASH_ADDR_LOW_OFS:  ptr_q.addr_low  <= reg_wdata_i;
        `FLASH_ADDR_HIGH_OFS: ptr_q.addr_high <= reg_wdata_i[3:0];
        `FLASH_DATA_LOW_OFS:  ptr_q.data_low  <= reg_wdata_i;
        `FLASH_DATA_HIGH_OFS: ptr_q.data_high <= reg_wdata_i[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        `FLASH_ADDR_LOW_OFS:  reg_rdata_o <= ptr_q.addr_low;
        `FLASH_ADDR_HIGH_OFS: reg_rdata_o <= {4'h0, ptr_q.addr_high};
        `FLASH_DATA_LOW_OFS:  reg_rdata_o <= ptr_q.data_low;
        `FLASH_DATA_HIGH_OFS: reg_rdata_o <= {2'b00, ptr_q.data_high};
        // control layout, bit 7 reads one
        `FLASH_CONTROL_OFS:   reg_rdata_o <= {1'b1, calibration_space_select_q, 3'b000, write_enable_bit_q, wr_q, rd_q};
        default:              reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // busy shown while an operation runs
  assign busy_o = rd_q || wr_q;

  // ***********************************************************
  // checks
  // ***********************************************************
  chk_read_timing: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    set_rd |=> rd_q ##1 rd_q ##1 !rd_q) else $error("read trigger timing wrong");
  chk_no_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_q && state_q == flash_ctl_pkg::ST_PROG && timer_q > 16'h0001) |=> wr_q)
    else $error("write trigger cleared early");
  chk_write_enable_bit_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_cmd && !new_write_enable_bit && !wr_q) |=> !wr_q) else $error("write without enable");
  chk_unlock_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_cmd && unlock_q != flash_ctl_pkg::UL_OPEN && !wr_q) |=> !wr_q)
    else $error("write without unlock");
  chk_unlock_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (reg_read_i && reg_addr_i == `FLASH_UNLOCK_OFS) |=> reg_rdata_o == 8'h00)
    else $error("unlock reads nonzero");
  chk_ctl_bit7: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (reg_read_i && reg_addr_i == `FLASH_CONTROL_OFS) |=> reg_rdata_o[7])
    else $error("control bit 7 not one");
  chk_cal_nowrite: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (set_wr && new_cal) |=> state_q == flash_ctl_pkg::ST_PROG ##1 !wr_q)
    else $error("write under calibration select");
  chk_write_ends: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (set_wr && !new_cal && lo2 == 2'b11) |-> ##[1:200] !wr_q)
    else $error("write never completed");
  chk_protect_skip: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (set_wr && blocked(prot_q, addr[11:0])) |=> !prog_q)
    else $error("write into protected block");
  chk_cp_deny: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !cp_n_q |=> !serial_port_grant_o) else $error("serial access under protect");
  cov_read: cover property (@(posedge clk_sys_i) set_rd);
  cov_cal_read: cover property (@(posedge clk_sys_i) set_rd && new_cal);
  cov_commit: cover property (@(posedge clk_sys_i) commit);
  cov_buffer: cover property (@(posedge clk_sys_i) set_wr && lo2 != 2'b11);

endmodule : flash_ctl
`default_nettype wire

// >>> core/flash_ctl_map.svh
// register offsets, fields, unlock values and timing for the flash self-access block
// assumes an 8-bit register port and a 40 MHz system clock for the controller's write cycle count
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH

`define FLASH_ADDR_LOW_OFS    3'h0
`define FLASH_ADDR_HIGH_OFS   3'h1
`define FLASH_DATA_LOW_OFS    3'h2
`define FLASH_DATA_HIGH_OFS   3'h3
`define FLASH_CONTROL_OFS     3'h4
`define FLASH_UNLOCK_OFS      3'h5

`define CTL_READ_BIT          0
`define CTL_WRITE_BIT         1
`define CTL_WRITE_ENABLE_BIT_BIT          2
`define CTL_CALIBRATION_SPACE_SELECT_BIT        6
`define CTL_ONE_BIT           7

`define UNLOCK_FIRST          8'h55
`define UNLOCK_SECOND         8'hAA

`define WORD_W                14
`define ADDR_W                13
`define LAST_USER_ADDR        13'h0fff
`define CAL_FILL              10'h2a5

`define WRITE_TIME_US         2
`define WRITE_CYCLES          ((`WRITE_TIME_US * 1000 + 24) / 25)

`endif

// >>> core/flash_ctl_pkg.sv
// types for the flash self-access block
// assumes flash_ctl_map.svh supplies the numbers
`include "flash_ctl_map.svh"

package flash_ctl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RWAIT = 3'b001,
    ST_READ  = 3'b010,
    ST_ERASE = 3'b011,
    ST_PROG  = 3'b100
  } state_type;

  typedef enum logic [1:0] {
    UL_NONE  = 2'b00,
    UL_FIRST = 2'b01,
    UL_OPEN  = 2'b10
  } unlock_type;

  typedef struct packed {
    logic [7:0] addr_low;
    logic [3:0] addr_high;
    logic [7:0] data_low;
    logic [5:0] data_high;
  } ptr_type;

endpackage : flash_ctl_pkg

// >>> tb/core_model.sv
// partner: software on the core, driving the flash register port
// assumes register offsets from flash_ctl_map.svh and a one-clock design
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_map.svh"

module core_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       busy_i,
  output var  logic [2:0] reg_addr_o,
  output var  logic [7:0] reg_wdata_o,
  output var  logic       reg_write_o,
  output var  logic       reg_read_o
);
  // ****************************************
  // register port cycles
  // ****************************************
  initial begin
    reg_addr_o  = 3'h7;
    reg_wdata_o = 8'h00;
    reg_write_o = 1'b0;
    reg_read_o  = 1'b0;
  end

  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_write_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_write_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask : put

  task automatic get(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_read_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_read_o <= 1'b0;
    #1 d = reg_rdata_i;
  endtask : get

  task automatic wait_idle();
    #1;
    for (int i = 0; i < 200 && busy_i !== 1'b0; i++) @(posedge clk_sys_i);
  endtask : wait_idle

  // high byte high, low byte low
  task automatic set_addr(input logic [11:0] a);
    put(`FLASH_ADDR_HIGH_OFS, {4'h0, a[11:8]});
    put(`FLASH_ADDR_LOW_OFS, a[7:0]);
  endtask : set_addr

  task automatic unlock();
    put(`FLASH_UNLOCK_OFS, `UNLOCK_FIRST);
    put(`FLASH_UNLOCK_OFS, `UNLOCK_SECOND);
  endtask : unlock

  task automatic word_write(input logic [11:0] a, input logic [13:0] w, input logic [7:0] c);
    set_addr(a);
    put(`FLASH_DATA_LOW_OFS, w[7:0]);
    put(`FLASH_DATA_HIGH_OFS, {2'b00, w[13:8]});
    unlock();
    put(`FLASH_CONTROL_OFS, c);
  endtask : word_write

  task automatic word_read(input logic [11:0] a, input logic [7:0] c, output logic [13:0] w);
    logic [7:0] lo;
    logic [7:0] hi;
    set_addr(a);
    put(`FLASH_CONTROL_OFS, c);
    wait_idle();
    get(`FLASH_DATA_LOW_OFS, lo);
    get(`FLASH_DATA_HIGH_OFS, hi);
    w = {hi[5:0], lo};
  endtask : word_read
endmodule : core_model
`default_nettype wire

// >>> tb/test_program_flash_access_control.sv
// bench: flash self-access block driven through the core model
// assumes flash_ctl_map.svh offsets and a 40 MHz system clock
`timescale 1ns/10ps
`default_nettype none
`include "flash_ctl_map.svh"

module test_program_flash_access_control;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic [1:0]  wp        = 2'b11;
  logic        cp_n      = 1'b1;
  logic        req       = 1'b0;
  logic        grant;
  logic        busy;
  logic [2:0]  ra;
  logic [7:0]  rwd;
  logic [7:0]  rrd;
  logic [7:0]  v;
  logic [7:0]  r;
  logic        rw;
  logic        rr;
  logic [13:0] w [4];
  logic [13:0] ex [4];
  logic [13:0] got;
  logic [11:0] base;
  int          bad_count = 0;
  int          compares  = 0;
  int          cycles    = 0;

  // ****************************************
  // clock, design, partner
  // ****************************************
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  flash_ctl dut (
    .clk_sys_i                  (clk_sys_i),
    .rst_n_i                    (rst_n_i),
    .reg_addr_i                 (ra),
    .reg_wdata_i                (rwd),
    .reg_write_i                (rw),
    .reg_read_i                 (rr),
    .reg_rdata_o                (rrd),
    .self_write_protect_field_i (wp),
    .code_protect_bit_n_i       (cp_n),
    .serial_port_req_i          (req),
    .serial_port_grant_o        (grant),
    .busy_o                     (busy)
  );

  core_model core (
    .clk_sys_i   (clk_sys_i),
    .reg_rdata_i (rrd),
    .busy_i      (busy),
    .reg_addr_o  (ra),
    .reg_wdata_o (rwd),
    .reg_write_o (rw),
    .reg_read_o  (rr)
  );

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic blk(input logic [7:0] c, input bit poke);
    for (int i = 0; i < 4; i++) begin
      core.word_write(base + 12'(i), w[i], c);
      if (poke && i == 3) begin
        core.put(`FLASH_CONTROL_OFS, 8'h04);
        core.get(`FLASH_CONTROL_OFS, v);
        chk("wr_held", 16'h0086, {8'h00, v});
      end
      core.wait_idle();
    end
    if (poke) begin
      core.get(`FLASH_CONTROL_OFS, v);
      chk("wr_cleared", 16'h0084, {8'h00, v});
    end
  endtask : blk

  function automatic logic [13:0] cal_exp(input logic [11:0] a);
    cal_exp = {`CAL_FILL, a[3:0]};
  endfunction : cal_exp

  task automatic readback(input string n);
    for (int i = 0; i < 4; i++) begin
      core.word_read(base + 12'(i), 8'h01, got);
      chk(n, {2'b00, ex[i]}, {2'b00, got});
    end
  endtask : readback

  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(87));
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    core.get(`FLASH_CONTROL_OFS, v);
    chk("ctl_reset", 16'h0080, {8'h00, v});
    core.get(3'h6, v);
    chk("unmapped", 16'h0000, {8'h00, v});
    $display("test reset done");
    r = 8'($urandom());
    core.put(`FLASH_ADDR_HIGH_OFS, r);
    core.get(`FLASH_ADDR_HIGH_OFS, v);
    chk("addr_high", {12'h000, r[3:0]}, {8'h00, v});
    core.put(`FLASH_DATA_HIGH_OFS, r);
    core.get(`FLASH_DATA_HIGH_OFS, v);
    chk("data_high", {10'h000, r[5:0]}, {8'h00, v});
    core.put(`FLASH_UNLOCK_OFS, r);
    core.get(`FLASH_UNLOCK_OFS, v);
    chk("unlock_read", 16'h0000, {8'h00, v});
    $display("test registers done");
    core.unlock();
    core.put(`FLASH_CONTROL_OFS, 8'h02);
    core.get(`FLASH_CONTROL_OFS, v);
    chk("wr_no_enable", 16'h0080, {8'h00, v});
    core.put(`FLASH_CONTROL_OFS, 8'h06);
    core.get(`FLASH_CONTROL_OFS, v);
    chk("wr_no_unlock", 16'h0084, {8'h00, v});
    $display("test refused done");
    cp_n <= 1'b0;
    req  <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      base = (k == 0) ? (12'($urandom()) & 12'hffc) : 12'hffc;
      foreach (w[i]) w[i] = 14'($urandom());
      blk(8'h06, k == 0);
      ex = w;
      readback("word_read");
      chk("grant_locked", 16'h0000, {15'h0000, grant});
    end
    $display("test block write done");
    r = 8'($urandom());
    core.word_read({4'h0, r}, 8'h41, got);
    chk("cal_read", {2'b00, cal_exp({4'h0, r})}, {2'b00, got});
    $display("test calibration read done");
    foreach (w[i]) w[i] = ~ex[i];
    blk(8'h46, 1'b0);
    readback("calibration_space_select_write");
    $display("test calibration_space_select done");
    wp <= 2'b00;
    blk(8'h06, 1'b0);
    readback("protected_write");
    wp <= 2'b11;
    $display("test protect done");
    cp_n <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1 chk("grant_open", 16'h0001, {15'h0000, grant});
    req <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1 chk("grant_idle", 16'h0000, {15'h0000, grant});
    $display("test serial port done");
    final_report();
  end
endmodule : test_program_flash_access_control
`default_nettype wire
